// ---- inc/cd_pkg.sv ----
// Shared types and constants for the instruction decode and execute core
package cd_pkg;
	typedef enum logic [6:0] {
		op_add, op_addc, op_sub, op_subc, op_addb, op_addcb, op_subb, op_subcb,
		op_cmp, op_cmpb, op_and, op_andb, op_or, op_orb, op_xor, op_xorb,
		op_mov, op_movb, op_mov_sx, op_mov_zx, op_cpl, op_cplb, op_neg, op_negb,
		op_mul, op_mulu, op_div, op_divu, op_div_long, op_div_longu,
		op_bclr, op_bset, op_bmov, op_bmovn, op_band, op_bor, op_bxor, op_bcmp,
		op_bfldh, op_bfldl, op_cmpd1, op_cmpd2, op_cmpi1, op_cmpi2, op_norm_cnt,
		op_shl, op_shr, op_rol, op_ror, op_asr, op_jmpr, op_jmps, op_jb, op_jnb,
		op_jmp_clr, op_jmp_set, op_callr, op_far_call, op_push_call, op_trap,
		op_push, op_pop, op_swap_ctx, op_ret, op_far_ret, op_ret_pop, op_reti,
		op_srst, op_idle, op_pwr_down, op_wdt_svc, op_wdt_off, op_init_end,
		op_atomic, op_ext_reg, op_ext_page, op_ext_page_reg, op_ext_seg,
		op_ext_seg_reg, op_nop
	} cd_op_t;

	typedef enum logic [2:0] {
		pfx_none, pfx_atomic, pfx_reg, pfx_page, pfx_page_reg, pfx_seg, pfx_seg_reg
	} cd_pfx_t;

	localparam logic [2:0]  LEN2        = 3'h2;
	localparam logic [2:0]  LEN4        = 3'h4;
	localparam int          OPB_LONG    = 7;
	localparam int          CFG_PD_POS  = 5;
	localparam logic [15:0] CFG_RST     = 16'h0000;

	typedef struct packed {
		logic v;
		logic c;
		logic n;
		logic z;
	} cd_flags_t;

	typedef struct packed {
		logic [7:0]  opb;
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] imm;
		logic [3:0]  bpos;
		logic [3:0]  bsrc;
	} cd_instr_t;

	typedef struct packed {
		logic        done;
		logic        wr;
		logic [15:0] data;
		logic        fl_wr;
		cd_flags_t   fl;
	} cd_res_t;

	typedef struct packed {
		logic        br;
		logic        far;
		logic        call;
		logic        ret;
		logic        reti;
		logic        push;
		logic        pop;
		logic        trap;
		logic        srst;
		logic        idle;
		logic        pd;
		logic        wdt_svc;
		logic        wdt_off;
		cd_pfx_t     pfx;
		logic [1:0]  pfx_cnt;
		logic [9:0]  pfx_val;
		logic [6:0]  trap_no;
		logic [7:0]  seg;
		logic [15:0] target;
		logic [15:0] push_data;
	} cd_ctl_t;

	// Length from opcode byte; bit 7 picks the long form only for op_add to op_mov_zx, compare-step and page/segment prefixes
	function automatic logic [2:0] cd_insn_len(input logic [7:0] opb);
		cd_op_t op;
		op = cd_op_t'(opb[6:0]);
		if (op inside {op_bmov, op_bmovn, op_band, op_bor, op_bxor, op_bcmp, op_bfldh,
				op_bfldl, op_jmpr, op_jmps, op_jb, op_jnb, op_jmp_clr, op_jmp_set,
				op_callr, op_far_call, op_push_call, op_swap_ctx, op_srst, op_idle,
				op_pwr_down, op_wdt_svc, op_wdt_off, op_init_end})
			return LEN4;
		if (op inside {[op_add:op_mov_zx], op_cmpd1, op_cmpd2, op_cmpi1, op_cmpi2,
				op_ext_page, op_ext_page_reg, op_ext_seg, op_ext_seg_reg})
			return opb[OPB_LONG] ? LEN4 : LEN2;
		return LEN2;
	endfunction
endpackage

// ---- core/cd_alu.sv ----
`timescale 1ns/1ps
// Word and byte arithmetic, logic and shift unit
module cd_alu (
	input  wire cd_pkg::cd_op_t op,
	input  wire logic [15:0]    a,
	input  wire logic [15:0]    b,
	input  wire logic           cin,
	output logic [15:0]         y,
	output cd_pkg::cd_flags_t   fl,
	output logic                wr
);
	logic        byt;
	logic        sub;
	logic        ci;
	logic        lg;
	logic        lb;
	logic [15:0] xa;
	logic [15:0] xb;
	logic [15:0] bb;
	logic [16:0] s;
	logic [15:0] t;
	logic [31:0] w;
	logic [3:0]  n;

	function automatic logic [15:0] norm_cnt(input logic [15:0] v);
		logic [15:0] c;
		logic        hit;
		c = 16'h0000;
		hit = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i])
				hit = 1'b1;
			else if (!hit && v != 16'h0000)
				c = c + 16'h0001;
		end
		return c;
	endfunction

	always_comb begin
		byt = op inside {cd_pkg::op_addb, cd_pkg::op_addcb, cd_pkg::op_subb, cd_pkg::op_subcb,
			cd_pkg::op_cmpb, cd_pkg::op_negb};
		sub = op inside {cd_pkg::op_sub, cd_pkg::op_subc, cd_pkg::op_subb, cd_pkg::op_subcb,
			cd_pkg::op_cmp, cd_pkg::op_cmpb, cd_pkg::op_neg, cd_pkg::op_negb,
			[cd_pkg::op_cmpd1:cd_pkg::op_cmpi2]};
		// Carry in for with-carry forms only; subtract takes it as borrow
		ci = (op inside {cd_pkg::op_addc, cd_pkg::op_addcb, cd_pkg::op_subc, cd_pkg::op_subcb})
			? (sub ? ~cin : cin) : sub; // RQ1
		xa = (op inside {cd_pkg::op_neg, cd_pkg::op_negb}) ? 16'h0000 : a; // RQ5
		xb = (op inside {cd_pkg::op_neg, cd_pkg::op_negb}) ? a : b;
		// Byte operands sit high so carry and overflow come out of bit 15
		if (byt) begin
			xa = {xa[7:0], 8'h00};
			xb = {xb[7:0], 8'h00};
		end
		bb = sub ? ~xb : xb;
		s = {1'b0, xa} + {1'b0, bb} + (byt ? {8'h00, ci, 8'h00} : {16'h0000, ci}); // RQ1
		y = byt ? {a[15:8], s[15:8]} : s[15:0];
		fl.c = sub ? ~s[16] : s[16];
		fl.v = (xa[15] == bb[15]) && (s[15] != xa[15]);
		fl.n = s[15];
		fl.z = byt ? (s[15:8] == 8'h00) : (s[15:0] == 16'h0000);
		wr = 1'b1;
		n = b[3:0];
		lg = 1'b1;
		lb = op inside {cd_pkg::op_andb, cd_pkg::op_orb, cd_pkg::op_xorb, cd_pkg::op_movb,
			cd_pkg::op_cplb};
		w = 32'h0000_0000;
		t = 16'h0000;
		unique case (op)
			cd_pkg::op_cmp, cd_pkg::op_cmpb: begin
				wr = 1'b0;
				lg = 1'b0;
			end
			cd_pkg::op_cmpd1: begin y = a - 16'h0001; lg = 1'b0; end // RQ8
			cd_pkg::op_cmpd2: begin y = a - 16'h0002; lg = 1'b0; end // RQ8
			cd_pkg::op_cmpi1: begin y = a + 16'h0001; lg = 1'b0; end // RQ8
			cd_pkg::op_cmpi2: begin y = a + 16'h0002; lg = 1'b0; end // RQ8
			cd_pkg::op_and, cd_pkg::op_andb: t = a & b;
			cd_pkg::op_or, cd_pkg::op_orb: t = a | b;
			cd_pkg::op_xor, cd_pkg::op_xorb: t = a ^ b;
			cd_pkg::op_mov, cd_pkg::op_movb: t = b;
			cd_pkg::op_mov_sx: t = {{8{b[7]}}, b[7:0]}; // RQ11
			cd_pkg::op_mov_zx: t = {8'h00, b[7:0]}; // RQ11
			cd_pkg::op_cpl, cd_pkg::op_cplb: t = ~a; // RQ5
			cd_pkg::op_norm_cnt: t = norm_cnt(b); // RQ9
			cd_pkg::op_shl: t = a << n; // RQ10
			cd_pkg::op_shr: t = a >> n; // RQ10
			cd_pkg::op_rol: begin
				w = {a, a} << n; // RQ10
				t = w[31:16];
			end
			cd_pkg::op_ror: begin
				w = {a, a} >> n; // RQ10
				t = w[15:0];
			end
			cd_pkg::op_asr: t = $signed(a) >>> n; // RQ10
			default: lg = 1'b0;
		endcase
		if (lg) begin
			y = lb ? {a[15:8], t[7:0]} : t;
			fl.v = 1'b0;
			fl.c = 1'b0;
			fl.n = lb ? t[7] : t[15];
			fl.z = lb ? (t[7:0] == 8'h00) : (t == 16'h0000);
		end
	end
endmodule

// ---- core/cd_div.sv ----
`timescale 1ns/1ps
// Iterative restoring divider, signed or unsigned, 2W by W bits
module cd_div #(
	parameter int W = 16
) (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           start,
	input  wire logic           sgn,
	input  wire logic [2*W-1:0] dvd,
	input  wire logic [W-1:0]   dvs,
	output logic                done,
	output logic                err,
	output logic [W-1:0]        quo,
	output logic [W-1:0]        rem
);
	localparam int CW = $clog2(2 * W) + 1;

	if (W < 2) begin : g_w_chk
		$error("W must be at least 2");
	end

	logic           busy_r;
	logic [CW-1:0]  cnt_r;
	logic [W-1:0]   r_r;
	logic [2*W-1:0] q_r;
	logic [W-1:0]   d_r;
	logic           qneg_r;
	logic           rneg_r;
	logic [W:0]     sh;

	assign sh = {r_r, q_r[2*W-1]};

	// Magnitudes first, signs patched at the end; one quotient bit per clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			cnt_r <= '0;
			r_r <= '0;
			q_r <= '0;
			d_r <= '0;
			qneg_r <= 1'b0;
			rneg_r <= 1'b0;
			done <= 1'b0;
			err <= 1'b0;
			quo <= '0;
			rem <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy_r) begin
				err <= 1'b0;
				if (dvs == '0) begin
					done <= 1'b1;
					err <= 1'b1;
				end else begin
					busy_r <= 1'b1;
					cnt_r <= CW'(2 * W);
					r_r <= '0;
					q_r <= (sgn && dvd[2*W-1]) ? -dvd : dvd;
					d_r <= (sgn && dvs[W-1]) ? -dvs : dvs;
					qneg_r <= sgn && (dvd[2*W-1] ^ dvs[W-1]);
					rneg_r <= sgn && dvd[2*W-1];
				end
			end else if (busy_r && cnt_r != '0) begin
				cnt_r <= cnt_r - CW'(1);
				if (sh >= {1'b0, d_r}) begin
					r_r <= W'(sh - {1'b0, d_r});
					q_r <= {q_r[2*W-2:0], 1'b1};
				end else begin
					r_r <= sh[W-1:0];
					q_r <= {q_r[2*W-2:0], 1'b0};
				end
			end else if (busy_r) begin
				busy_r <= 1'b0;
				done <= 1'b1;
				// Quotient that does not fit W bits is reported, not saturated
				err <= (q_r[2*W-1:W] != '0) || (sgn && q_r[W-1] && !(qneg_r && q_r[W-2:0] == '0));
				quo <= qneg_r ? -q_r[W-1:0] : q_r[W-1:0];
				rem <= rneg_r ? -r_r : r_r;
			end
		end
	end
endmodule

// ---- core/cd_exec.sv ----
`timescale 1ns/1ps
// Instruction decode and execute core
// How it works
// RQ1: Add and subtract, word or byte, carry optional
// RQ2: Signed or unsigned 16x16 register multiply
// RQ3: Divide low muldiv half by register
// RQ4: Divide full 32-bit muldiv by register
// RQ5: Complement and negate word or byte register
// RQ6: Bit clear/set; bit move, logic, compare
// RQ7: Masked byte field update from immediate data
// RQ8: Compare, then step register by one or two
// RQ9: Store normalise shift count in second register
// RQ10: Shifts, rotates and sign-keeping right shift
// RQ11: Byte to word with sign or zero fill
// RQ12: Jump and clear set bit, jump and set clear bit
// RQ13: Push register then load it with operand
// RQ14: Call pushing register; return popping it
// RQ15: Far call to any segment, far return
// RQ16: Trap number selects the service routine
// RQ17: Power-down assumes interrupt pin held low
// RQ18: End of initialisation releases reset output pin
// RQ19: Atomic, register, page and segment prefixes
// RQ20: Power-down ignored unless pin low when configured; when configured the code gates on exint_idle instead of the pin
// RQ21: Configuration writes ignored after end of initialisation
// RQ22: Length two or four from first byte
module cd_exec (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              req,
	input  wire cd_pkg::cd_instr_t instr,
	input  wire logic [15:0]       pc,
	input  wire logic              cond_met,
	input  wire logic              carry_in,
	output logic                   ready,
	output logic [2:0]             insn_len,
	input  wire logic              md_wr,
	input  wire logic [31:0]       md_wdata,
	output logic [31:0]            muldiv_full_reg,
	output logic [15:0]            muldiv_low_reg,
	input  wire logic              cfg_wr,
	input  wire logic [15:0]       cfg_wdata,
	output logic [15:0]            system_config_reg,
	input  wire logic              nmi_n,
	input  wire logic              exint_idle,
	output cd_pkg::cd_res_t        res,
	output cd_pkg::cd_ctl_t        ctl,
	output logic                   reset_out_pin_n
);
	typedef enum logic {st_idle, st_div} cd_st_t;

	cd_st_t            st_r;
	cd_pkg::cd_op_t    op;
	logic              take;
	logic [15:0]       alu_y;
	cd_pkg::cd_flags_t alu_fl;
	logic              alu_wr;
	logic              div_start;
	logic              div_sgn;
	logic [31:0]       div_dvd;
	logic              div_done;
	logic              div_err;
	logic [15:0]       div_quo;
	logic [15:0]       div_rem;
	logic [31:0]       prod;
	logic              dbit;
	logic              sbit;
	logic [15:0]       rel;
	logic [15:0]       bit_y;
	logic [7:0]        fld;
	logic [2:0]        nmi_s_r;
	logic              nmi_lvl_r;
	logic              init_done_r;
	logic [15:0]       sys_cfg_r;
	logic [31:0]       md_r;
	logic              pd_ok;

	function automatic logic [15:0] put_bit(input logic [15:0] w, input logic [3:0] p, input logic v);
		logic [15:0] m;
		m = 16'h0001 << p;
		return v ? (w | m) : (w & ~m);
	endfunction

	assign op = cd_pkg::cd_op_t'(instr.opb[6:0]);
	assign insn_len = cd_pkg::cd_insn_len(instr.opb); // RQ22
	// Divide by a non-zero register holds off the next instruction
	assign ready = (st_r == st_idle);
	assign take = req && ready;
	assign muldiv_full_reg = md_r;
	assign muldiv_low_reg = md_r[15:0];
	assign system_config_reg = sys_cfg_r;

	cd_alu u_alu (
		.op  (op),
		.a   (instr.a),
		.b   (instr.b),
		.cin (carry_in),
		.y   (alu_y),
		.fl  (alu_fl),
		.wr  (alu_wr)
	);

	assign div_start = take && (op inside {[cd_pkg::op_div:cd_pkg::op_div_longu]});
	assign div_sgn = op inside {cd_pkg::op_div, cd_pkg::op_div_long};
	assign div_dvd = (op inside {cd_pkg::op_div_long, cd_pkg::op_div_longu}) ? md_r // RQ4
		: (div_sgn ? {{16{md_r[15]}}, md_r[15:0]} : {16'h0000, md_r[15:0]}); // RQ3

	cd_div #(
		.W (16)
	) u_div (
		.clk   (clk),
		.rst_n (rst_n),
		.start (div_start),
		.sgn   (div_sgn),
		.dvd   (div_dvd),
		.dvs   (instr.b),
		.done  (div_done),
		.err   (div_err),
		.quo   (div_quo),
		.rem   (div_rem)
	);

	always_comb begin
		prod = (op == cd_pkg::op_mul) ? 32'($signed(instr.a) * $signed(instr.b)) // RQ2
			: 32'(instr.a * instr.b); // RQ2
		dbit = instr.a[instr.bpos];
		sbit = instr.b[instr.bsrc];
		rel = pc + {13'h0000, insn_len} + {{7{instr.imm[7]}}, instr.imm[7:0], 1'b0};
		fld = instr.opb[6:0] == 7'(cd_pkg::op_bfldh) ? instr.a[15:8] : instr.a[7:0];
		fld = (fld & ~instr.imm[7:0]) | (instr.imm[15:8] & instr.imm[7:0]); // RQ7
		bit_y = instr.a;
		unique case (op)
			cd_pkg::op_bclr: bit_y = put_bit(instr.a, instr.bpos, 1'b0); // RQ6
			cd_pkg::op_bset: bit_y = put_bit(instr.a, instr.bpos, 1'b1); // RQ6
			cd_pkg::op_bmov: bit_y = put_bit(instr.a, instr.bpos, sbit); // RQ6
			cd_pkg::op_bmovn: bit_y = put_bit(instr.a, instr.bpos, ~sbit); // RQ6
			cd_pkg::op_band: bit_y = put_bit(instr.a, instr.bpos, dbit & sbit); // RQ6
			cd_pkg::op_bor: bit_y = put_bit(instr.a, instr.bpos, dbit | sbit); // RQ6
			cd_pkg::op_bxor: bit_y = put_bit(instr.a, instr.bpos, dbit ^ sbit); // RQ6
			cd_pkg::op_bfldh: bit_y = {fld, instr.a[7:0]}; // RQ7
			cd_pkg::op_bfldl: bit_y = {instr.a[15:8], fld}; // RQ7
			cd_pkg::op_jmp_clr: bit_y = put_bit(instr.a, instr.bpos, 1'b0); // RQ12
			cd_pkg::op_jmp_set: bit_y = put_bit(instr.a, instr.bpos, 1'b1); // RQ12
			default: bit_y = instr.a;
		endcase
		// Power-down gate: pin low, or idle fast interrupts if configured
		pd_ok = sys_cfg_r[cd_pkg::CFG_PD_POS] ? exint_idle : !nmi_lvl_r; // RQ17 RQ20
	end

	// Three stages on the pin; the level moves only when the last two agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_s_r <= 3'h7;
			nmi_lvl_r <= 1'b1;
		end else begin
			nmi_s_r <= {nmi_s_r[1:0], nmi_n};
			if (nmi_s_r[1] == nmi_s_r[2])
				nmi_lvl_r <= nmi_s_r[2];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_r <= st_idle;
		else if (div_start && instr.b != 16'h0000)
			st_r <= st_div;
		else if (div_done)
			st_r <= st_idle;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			md_r <= 32'h0000_0000;
		else if (div_done && !div_err)
			md_r <= {div_rem, div_quo}; // RQ3 RQ4
		else if (take && (op inside {cd_pkg::op_mul, cd_pkg::op_mulu}))
			md_r <= prod; // RQ2
		else if (md_wr)
			md_r <= md_wdata;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_done_r <= 1'b0;
			reset_out_pin_n <= 1'b0;
			sys_cfg_r <= cd_pkg::CFG_RST;
		end else begin
			if (take && op == cd_pkg::op_init_end) begin
				init_done_r <= 1'b1; // RQ18
				reset_out_pin_n <= 1'b1; // RQ18
			end
			if (cfg_wr && !init_done_r)
				sys_cfg_r <= cfg_wdata; // RQ21
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res <= '0;
		end else begin
			res.done <= 1'b0;
			res.wr <= 1'b0;
			res.fl_wr <= 1'b0;
			if (div_done) begin
				res.done <= 1'b1;
				res.fl_wr <= 1'b1;
				res.fl <= '{v: div_err, c: 1'b0, n: div_quo[15], z: div_quo == 16'h0000};
			end else if (take && !div_start) begin
				res.done <= 1'b1;
				if (op inside {[cd_pkg::op_add:cd_pkg::op_negb], [cd_pkg::op_cmpd1:cd_pkg::op_asr]}) begin
					res.wr <= alu_wr; // RQ1 RQ5 RQ8 RQ9 RQ10 RQ11
					res.data <= alu_y;
					res.fl_wr <= 1'b1;
					res.fl <= alu_fl;
				end else if (op inside {[cd_pkg::op_bclr:cd_pkg::op_bfldl]}) begin
					res.wr <= (op != cd_pkg::op_bcmp); // RQ6
					res.data <= bit_y;
					res.fl_wr <= 1'b1;
					res.fl <= '{v: dbit | sbit, c: dbit & sbit, n: dbit ^ sbit, z: ~dbit};
				end else if (op inside {cd_pkg::op_mul, cd_pkg::op_mulu}) begin
					res.fl_wr <= 1'b1;
					res.fl <= '{v: 1'b0, c: 1'b0, n: prod[31], z: prod == 32'h0000_0000};
				end else if ((op == cd_pkg::op_jmp_clr && dbit) || (op == cd_pkg::op_jmp_set && !dbit)) begin
					res.wr <= 1'b1; // RQ12
					res.data <= bit_y;
				end else if (op == cd_pkg::op_swap_ctx) begin
					res.wr <= 1'b1; // RQ13
					res.data <= instr.b;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= '0;
		end else begin
			ctl <= '0;
			if (take) begin
				unique case (op)
					cd_pkg::op_jmpr: begin
						ctl.br <= cond_met;
						ctl.target <= rel;
					end
					cd_pkg::op_jmps: begin
						ctl.br <= 1'b1;
						ctl.far <= 1'b1;
						ctl.seg <= instr.b[7:0];
						ctl.target <= instr.imm;
					end
					cd_pkg::op_jb, cd_pkg::op_jnb, cd_pkg::op_jmp_clr, cd_pkg::op_jmp_set: begin
						ctl.br <= (op == cd_pkg::op_jb || op == cd_pkg::op_jmp_clr) ? dbit : !dbit; // RQ12
						ctl.target <= rel;
					end
					cd_pkg::op_callr: begin
						ctl.br <= cond_met;
						ctl.call <= cond_met;
						ctl.target <= rel;
					end
					cd_pkg::op_far_call: begin
						ctl.br <= 1'b1; // RQ15
						ctl.call <= 1'b1;
						ctl.far <= 1'b1;
						ctl.seg <= instr.b[7:0];
						ctl.target <= instr.imm;
					end
					cd_pkg::op_push_call: begin
						ctl.push <= 1'b1; // RQ14
						ctl.push_data <= instr.a;
						ctl.br <= 1'b1;
						ctl.call <= 1'b1;
						ctl.target <= instr.imm;
					end
					cd_pkg::op_trap: begin
						ctl.trap <= 1'b1; // RQ16
						ctl.trap_no <= instr.imm[6:0];
					end
					cd_pkg::op_push, cd_pkg::op_swap_ctx: begin
						ctl.push <= 1'b1; // RQ13
						ctl.push_data <= instr.a;
					end
					cd_pkg::op_pop: ctl.pop <= 1'b1;
					cd_pkg::op_ret: ctl.ret <= 1'b1;
					cd_pkg::op_far_ret: begin
						ctl.ret <= 1'b1; // RQ15
						ctl.far <= 1'b1;
					end
					cd_pkg::op_ret_pop: begin
						ctl.ret <= 1'b1; // RQ14
						ctl.pop <= 1'b1;
					end
					cd_pkg::op_reti: ctl.reti <= 1'b1;
					cd_pkg::op_srst: ctl.srst <= 1'b1;
					cd_pkg::op_idle: ctl.idle <= 1'b1;
					cd_pkg::op_pwr_down: ctl.pd <= pd_ok; // RQ17 RQ20
					cd_pkg::op_wdt_svc: ctl.wdt_svc <= 1'b1;
					cd_pkg::op_wdt_off: ctl.wdt_off <= !init_done_r;
					cd_pkg::op_atomic, cd_pkg::op_ext_reg, cd_pkg::op_ext_page,
					cd_pkg::op_ext_page_reg, cd_pkg::op_ext_seg, cd_pkg::op_ext_seg_reg: begin
						ctl.pfx <= cd_pkg::cd_pfx_t'(3'(op - cd_pkg::op_atomic + 7'h01)); // RQ19
						ctl.pfx_cnt <= instr.imm[1:0];
						ctl.pfx_val <= instr.b[9:0];
					end
					default: ;
				endcase
			end
		end
	end
endmodule

// ---- tb/cd_exec_assertions.sv ----
// Port-level property checker for the decode and execute core
`timescale 1ns/1ps
module cd_exec_checker (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              req,
	input wire logic              ready,
	input wire cd_pkg::cd_instr_t instr,
	input wire logic [2:0]        insn_len,
	input wire logic [15:0]       system_config_reg,
	input wire logic              nmi_n,
	input wire cd_pkg::cd_res_t   res,
	input wire cd_pkg::cd_ctl_t   ctl,
	input wire logic              reset_out_pin_n
);
	default clocking dflt @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic       take;
	logic [6:0] op;
	assign take = req && ready;
	assign op = instr.opb[6:0];
	// Five samples cover the three-flop synchroniser on the pin
	sequence pin_high_s;
		nmi_n [*5];
	endsequence
	sequence pin_low_s;
		!nmi_n [*5];
	endsequence
	sequence pd_take_s;
		take && op == cd_pkg::op_pwr_down && !system_config_reg[5];
	endsequence
	len_four_a:
		assert property (op inside {cd_pkg::op_init_end, cd_pkg::op_bmov, cd_pkg::op_jmp_clr} |-> insn_len == 3'h4)
		else $error("long length");
	len_two_a:
		assert property (op inside {cd_pkg::op_div_long, cd_pkg::op_divu, cd_pkg::op_trap} |-> insn_len == 3'h2)
		else $error("short length");
	add_result_a:
		assert property (take && op == cd_pkg::op_add |=> res.done && res.wr
			&& res.data == $past(instr.a) + $past(instr.b)) else $error("add result");
	cpl_result_a:
		assert property (take && op == cd_pkg::op_cpl |=> res.wr && res.data == ~$past(instr.a))
		else $error("cpl result");
	sign_fill_a:
		assert property (take && op == cd_pkg::op_mov_sx |=> res.data == {{8{$past(instr.b[7])}}, $past(instr.b[7:0])})
		else $error("sign fill");
	div_busy_a:
		assert property (take && op == cd_pkg::op_divu && instr.b != 16'h0000 |=> !ready [*8])
		else $error("div not busy");
	init_pin_a:
		assert property (take && op == cd_pkg::op_init_end |=> reset_out_pin_n) else $error("pin not released");
	pin_holds_a:
		assert property (reset_out_pin_n |=> reset_out_pin_n) else $error("pin fell");
	cfg_locked_a:
		assert property (reset_out_pin_n |=> $stable(system_config_reg)) else $error("cfg changed");
	pd_blocked_a:
		assert property (pin_high_s ##0 pd_take_s |=> !ctl.pd) else $error("pd with pin high");
	pd_entered_a:
		assert property (pin_low_s ##0 pd_take_s |=> ctl.pd) else $error("pd missing");
endmodule
bind cd_exec cd_exec_checker cd_exec_checker_inst (.clk(clk), .rst_n(rst_n), .req(req), .ready(ready),
	.instr(instr), .insn_len(insn_len), .system_config_reg(system_config_reg), .nmi_n(nmi_n),
	.res(res), .ctl(ctl), .reset_out_pin_n(reset_out_pin_n));

// ---- tb/cd_fetch_model.sv ----
// Fetch stand-in: offers one instruction, holds it until taken, steps the address
`timescale 1ns/1ps
module cd_fetch_model (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ready,
	input  wire logic [2:0]        insn_len,
	input  wire logic              go,
	input  wire cd_pkg::cd_instr_t nxt,
	output logic                   req,
	output cd_pkg::cd_instr_t      instr,
	output logic [15:0]            pc
);
	// Released word is inverted so stale operands look wrong
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req <= 1'b0;
			instr <= '0;
			pc <= 16'h100;
		end else if (req && ready) begin
			req <= 1'b0;
			instr <= ~instr;
			pc <= pc + 16'(insn_len);
		end else if (go && !req) begin
			req <= 1'b1;
			instr <= nxt;
		end
	end
endmodule

// ---- tb/test_cpu_instruction_decode.sv ----
// Self-checking bench for the decode and execute core
`timescale 1ns/1ps
module test_cpu_instruction_decode;
	logic              clk, rst_n, go, cond_met, carry_in, md_wr, cfg_wr, nmi_n, exint_idle;
	logic              req, ready, reset_out_pin_n;
	logic [2:0]        insn_len, plen;
	logic [15:0]       pc, pc0, cfg_wdata, system_config_reg, muldiv_low_reg;
	logic [31:0]       md_wdata, muldiv_full_reg;
	cd_pkg::cd_instr_t nxt, instr;
	cd_pkg::cd_res_t   res;
	cd_pkg::cd_ctl_t   ctl;
	int                miscompares, checked;
	cd_fetch_model cd_fetch_model_inst (.clk(clk), .rst_n(rst_n), .ready(ready), .insn_len(insn_len),
		.go(go), .nxt(nxt), .req(req), .instr(instr), .pc(pc));
	cd_exec cd_exec_inst (.clk(clk), .rst_n(rst_n), .req(req), .instr(instr), .pc(pc), .cond_met(cond_met),
		.carry_in(carry_in), .ready(ready), .insn_len(insn_len), .md_wr(md_wr), .md_wdata(md_wdata),
		.muldiv_full_reg(muldiv_full_reg), .muldiv_low_reg(muldiv_low_reg), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .system_config_reg(system_config_reg), .nmi_n(nmi_n),
		.exint_idle(exint_idle), .res(res), .ctl(ctl), .reset_out_pin_n(reset_out_pin_n));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Offers one instruction, waits for done
	task automatic issue(input cd_pkg::cd_op_t op, input logic lng, input logic [15:0] a = 16'h0, b = 16'h0,
			input logic [15:0] imm = 16'h0, input int lim = 40);
		int n;
		n = 0;
		pc0 = pc;
		nxt = '{opb: {lng, op}, a: a, b: b, imm: imm, bpos: 4'h3, bsrc: 4'h2};
		go = 1'b1;
		@(posedge clk);
		#1;
		go = 1'b0;
		while (res.done !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				miscompares++;
				tally_and_finish();
			end
		end
		plen = 3'(pc - pc0);
	endtask
	task automatic op_chk(input cd_pkg::cd_op_t op, input logic lng, input logic [15:0] a, b, exp,
			input logic [2:0] elen, input logic [15:0] imm = 16'h0);
		issue(op, lng, a, b, imm, 4);
		chk(res.data, exp);
		chk(plen, elen);
	endtask
	task automatic poke(input logic is_md, input logic [31:0] v);
		md_wdata = v;
		cfg_wdata = v[15:0];
		md_wr = is_md;
		cfg_wr = !is_md;
		@(posedge clk);
		#1;
		md_wr = 1'b0;
		cfg_wr = 1'b0;
	endtask
	task automatic t_alu;
		op_chk(cd_pkg::op_add, 1, 16'hFFFF, 16'h2, 16'h1, 3'h4);
		chk({res.wr, res.fl.c}, 2'h3);
		carry_in = 1'b1;
		op_chk(cd_pkg::op_addc, 0, 16'h1, 16'h2, 16'h4, 3'h2);
		carry_in = 1'b0;
		op_chk(cd_pkg::op_subb, 0, 16'h1205, 16'h7, 16'h12FE, 3'h2);
		op_chk(cd_pkg::op_negb, 0, 16'h1205, 16'h0, 16'h12FB, 3'h2);
		op_chk(cd_pkg::op_cpl, 0, 16'h5, 16'h0, 16'hFFFA, 3'h2);
		op_chk(cd_pkg::op_cmpd2, 1, 16'hA, 16'hA, 16'h8, 3'h4);
		op_chk(cd_pkg::op_cmpi1, 0, 16'hA, 16'h3, 16'hB, 3'h2);
		op_chk(cd_pkg::op_norm_cnt, 0, 16'h100, 16'h100, 16'h7, 3'h2);
		op_chk(cd_pkg::op_shr, 0, 16'h8000, 16'h4, 16'h800, 3'h2);
		op_chk(cd_pkg::op_rol, 0, 16'h8001, 16'h1, 16'h3, 3'h2);
		op_chk(cd_pkg::op_asr, 0, 16'h8000, 16'h4, 16'hF800, 3'h2);
		op_chk(cd_pkg::op_mov_sx, 1, 16'h1234, 16'h80, 16'hFF80, 3'h4);
		op_chk(cd_pkg::op_mov_zx, 0, 16'h1234, 16'h80, 16'h80, 3'h2);
	endtask
	task automatic t_bits;
		op_chk(cd_pkg::op_bclr, 0, 16'hFFFF, 16'h0, 16'hFFF7, 3'h2);
		op_chk(cd_pkg::op_bset, 0, 16'h0, 16'h0, 16'h8, 3'h2);
		op_chk(cd_pkg::op_bmov, 0, 16'h0, 16'h4, 16'h8, 3'h4);
		op_chk(cd_pkg::op_bmovn, 0, 16'hFFFF, 16'h4, 16'hFFF7, 3'h4);
		op_chk(cd_pkg::op_bfldl, 0, 16'hFFFF, 16'h0, 16'hFFF5, 3'h4, 16'h50F);
		op_chk(cd_pkg::op_bfldh, 0, 16'h0, 16'h0, 16'h3000, 3'h4, 16'h30F0);
		op_chk(cd_pkg::op_jmp_clr, 0, 16'h8, 16'h0, 16'h0, 3'h4, 16'h2);
		chk({ctl.br, ctl.target}, {1'b1, pc0 + 16'h8});
		op_chk(cd_pkg::op_jmp_set, 0, 16'h0, 16'h0, 16'h8, 3'h4, 16'hFE);
		chk({ctl.br, ctl.target}, {1'b1, pc0});
		issue(cd_pkg::op_jmp_clr, 0, 16'h0, 16'h0, 16'h2);
		chk(ctl.br, 1'b0);
	endtask
	task automatic t_muldiv;
		issue(cd_pkg::op_mulu, 0, 16'hFFFF, 16'hFFFF, 16'h0, 4);
		chk(muldiv_full_reg, 32'hFFFE0001);
		issue(cd_pkg::op_mul, 0, 16'hFFFF, 16'hFFFF, 16'h0, 4);
		chk(muldiv_full_reg, 32'h1);
		poke(1, 32'h64);
		issue(cd_pkg::op_divu, 0, 16'h0, 16'h7);
		chk(muldiv_full_reg, 32'h2000E);
		poke(1, 32'hFFF9);
		issue(cd_pkg::op_div, 0, 16'h0, 16'h2);
		chk(muldiv_full_reg, 32'hFFFFFFFD);
		poke(1, 32'h10000);
		issue(cd_pkg::op_div_longu, 1, 16'h0, 16'h10);
		chk({muldiv_low_reg, plen}, {16'h1000, 3'h2});
		issue(cd_pkg::op_div_long, 0);
		chk(res.fl.v, 1'b1);
		chk(muldiv_full_reg, 32'h1000);
	endtask
	task automatic t_flow;
		op_chk(cd_pkg::op_swap_ctx, 0, 16'h1111, 16'h2222, 16'h2222, 3'h4);
		chk({ctl.push, ctl.push_data}, {1'b1, 16'h1111});
		issue(cd_pkg::op_push_call, 0, 16'h3333);
		chk({ctl.push, ctl.call, ctl.push_data}, {2'h3, 16'h3333});
		issue(cd_pkg::op_ret_pop, 0);
		chk({ctl.ret, ctl.pop, plen}, {2'h3, 3'h2});
		issue(cd_pkg::op_far_call, 0);
		chk({ctl.call, ctl.far, plen}, {2'h3, 3'h4});
		issue(cd_pkg::op_far_ret, 0);
		chk({ctl.ret, plen}, {1'b1, 3'h2});
		issue(cd_pkg::op_trap, 0, 16'h0, 16'h0, 16'h15);
		chk({ctl.trap, ctl.trap_no, plen}, {1'b1, 7'h15, 3'h2});
		issue(cd_pkg::op_ext_page, 1);
		chk({ctl.pfx, plen}, {cd_pkg::pfx_page, 3'h4});
		issue(cd_pkg::op_atomic, 0);
		chk(ctl.pfx, cd_pkg::pfx_atomic);
	endtask
	task automatic t_power;
		issue(cd_pkg::op_pwr_down, 0);
		chk({ctl.pd, plen}, {1'b0, 3'h4});
		nmi_n = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		issue(cd_pkg::op_pwr_down, 0);
		chk(ctl.pd, 1'b1);
		nmi_n = 1'b1;
		poke(0, 32'h20);
		exint_idle = 1'b1;
		issue(cd_pkg::op_pwr_down, 0);
		chk(ctl.pd, 1'b1);
		exint_idle = 1'b0;
		issue(cd_pkg::op_pwr_down, 0);
		chk(ctl.pd, 1'b0);
	endtask
	task automatic t_init;
		chk(system_config_reg, 16'h20);
		issue(cd_pkg::op_init_end, 0);
		chk({reset_out_pin_n, plen}, {1'b1, 3'h4});
		poke(0, 32'h0);
		@(posedge clk);
		#1;
		chk(system_config_reg, 16'h20);
	endtask
	initial begin
		{rst_n, go, cond_met, carry_in, md_wr, cfg_wr, exint_idle, nxt, md_wdata, cfg_wdata, miscompares, checked} = '0;
		nmi_n = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk(reset_out_pin_n, 1'b0);
		chk(system_config_reg, cd_pkg::CFG_RST);
		t_alu();
		t_bits();
		t_muldiv();
		t_flow();
		t_power();
		t_init();
		tally_and_finish();
	end
endmodule
